// *** cadp_aux_file.sv ***
// eight-entry auxiliary register file with pointer and address unit
// assumes one request per cycle from instruction decode
`timescale 1ns/1ps
`default_nettype none
`include "cadp_cfg.svh"
module cadp_aux_file #(
  parameter int N = `CADP_AR_N
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire cadp_pkg::cadp_aux_req_s req_in,
  input wire logic [15:0] data_bus_in,
  input wire logic [31:0] accum_in,
  input wire logic [31:0] product_in,
  input wire logic [2:0] rd_sel_in,
  output logic [15:0] rd_data_out,
  output cadp_pkg::cadp_aux_state_s aux_state_out
);
  import cadp_pkg::*;
  typedef struct packed {
    logic [N-1:0][15:0] ar;
    logic [2:0] ptr;
    logic [15:0] addr;
    logic [15:0] rd;
  } cadp_auxst_s;
  cadp_auxst_s st_r, st_nxt;
  logic [15:0] src_val;
  logic [15:0] cur;
  // source mux shared by register and pointer loads
  always_comb begin
    unique case (req_in.src)
      CADP_SRC_DATA: src_val = data_bus_in;
      CADP_SRC_ACC: src_val = accum_in[15:0];
      CADP_SRC_PRODUCT: src_val = product_in[15:0];
      CADP_SRC_IMM: src_val = req_in.imm;
    endcase
  end
  // address from selected register, then autoindex in same access
  always_comb begin
    st_nxt = st_r;
    cur = st_r.ar[st_r.ptr];
    st_nxt.rd = st_r.ar[rd_sel_in];
    if (req_in.addr_access) begin
      st_nxt.addr = cur;
      unique case (req_in.aau)
        CADP_AAU_NONE: st_nxt.ar[st_r.ptr] = cur;
        CADP_AAU_INC: st_nxt.ar[st_r.ptr] = cur + 16'h0001;
        CADP_AAU_DEC: st_nxt.ar[st_r.ptr] = cur - 16'h0001;
        CADP_AAU_ADD0: st_nxt.ar[st_r.ptr] = cur + st_r.ar[0];
        CADP_AAU_SUB0: st_nxt.ar[st_r.ptr] = cur - st_r.ar[0];
        default: st_nxt.ar[st_r.ptr] = cur;
      endcase
    end
    if (req_in.ar_load)
      st_nxt.ar[st_r.ptr] = src_val;
    if (req_in.ptr_load)
      st_nxt.ptr = (req_in.src == CADP_SRC_IMM) ? req_in.imm_ptr : src_val[2:0];
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign rd_data_out = st_r.rd;
  assign aux_state_out.ptr = st_r.ptr;
  assign aux_state_out.addr = st_r.addr;
endmodule
`default_nettype wire

// *** cadp_cfg.svh ***
// constants for the carry/accumulator/aux-register datapath slice
// assumes inclusion by bare name from package and modules
`ifndef CADP_CFG_SVH
`define CADP_CFG_SVH
`define CADP_CARRY_RST 1'b1
`define CADP_ACC_W 32
`define CADP_HALF_W 16
`define CADP_AR_N 8
`define CADP_AR_W 16
`define CADP_PTR_W 3
`define CADP_SHIFT_W 3
`define CADP_SAT_POS 32'h7fffffff
`define CADP_SAT_NEG 32'h80000000
`define CADP_HIGH_SHIFT 16
`endif

// *** cadp_pkg.sv ***
// types for the carry/accumulator/aux-register datapath slice
// assumes cadp_cfg.svh is reachable by include path
`include "cadp_cfg.svh"
package cadp_pkg;
  typedef enum logic [4:0] {
    CADP_OP_NOP, CADP_OP_LOAD, CADP_OP_ADD, CADP_OP_SUB, CADP_OP_ADD_HIGH, CADP_OP_SUB_HIGH,
    CADP_OP_ADD_WITH_CARRY, CADP_OP_SUB_WITH_BORROW, CADP_OP_AND, CADP_OP_OR, CADP_OP_XOR,
    CADP_OP_SET_FLAG, CADP_OP_CLEAR_FLAG, CADP_OP_STATUS_LOAD,
    CADP_OP_SHIFT_LEFT_INPLACE, CADP_OP_SHIFT_RIGHT_INPLACE, CADP_OP_ROTATE_LEFT, CADP_OP_ROTATE_RIGHT
  } cadp_op_e;
  typedef enum logic [1:0] {CADP_SRC_DATA, CADP_SRC_ACC, CADP_SRC_PRODUCT, CADP_SRC_IMM} cadp_src_e;
  typedef enum logic [2:0] {CADP_AAU_NONE, CADP_AAU_INC, CADP_AAU_DEC, CADP_AAU_ADD0, CADP_AAU_SUB0} cadp_aau_e;
  typedef enum logic [1:0] {CADP_COND_ALWAYS, CADP_COND_CARRY, CADP_COND_NO_CARRY} cadp_cond_e;
  typedef struct packed {
    logic valid;
    cadp_op_e op;
    logic [31:0] operand;
    logic status_carry;
  } cadp_alu_req_s;
  typedef struct packed {
    logic ar_load;
    logic ptr_load;
    cadp_src_e src;
    logic [15:0] imm;
    logic [2:0] imm_ptr;
    cadp_aau_e aau;
    logic addr_access;
  } cadp_aux_req_s;
  typedef struct packed {
    logic [31:0] accum;
    logic carry;
    logic overflow;
  } cadp_core_state_s;
  typedef struct packed {
    logic [2:0] ptr;
    logic [15:0] addr;
  } cadp_aux_state_s;
endpackage

// *** cadp_post_shifter.sv ***
// output post-scaling shifter for storing accumulator halves
// assumes accum value is registered upstream; output registered here
`timescale 1ns/1ps
`default_nettype none
module cadp_post_shifter (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] accum_in,
  input wire logic [2:0] shift_in,
  input wire logic high_sel_in,
  output logic [15:0] store_data_out
);
  import cadp_pkg::*;
  typedef struct packed {logic [15:0] data;} cadp_shst_s;
  cadp_shst_s st_r, st_nxt;
  logic [47:0] wide;
  // shift accum plus zero pad, then pick the window; accum itself never changes
  always_comb begin
    st_nxt = st_r;
    wide = {16'h0000, accum_in} << shift_in;
    if (high_sel_in)
      st_nxt.data = wide[31:16]; // top bits lost, low filled from lower half
    else
      st_nxt.data = wide[15:0]; // vacated low bits zero
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign store_data_out = st_r.data;
endmodule
`default_nettype wire

// *** cadp_top.sv ***
// carry flag, accumulator and aux-register datapath slice of the core
// assumes decode presents one op per cycle; repeat logic re-issues ops
// Summary of operation
// - carry changes on arithmetic, single-bit shifts/rotates and set/clear/status load only
// - add/sub with carry use previous carry
// - add-high only sets carry on carry
// - sub-high only clears carry on borrow
// - carry conditions; set, clear, status load
// - reset forces carry to one
// - 32-bit accumulator, halves stored separately
// - store path shift 0..7, accumulator unchanged
// - high store fills from lower half
// - low store zero-fills vacated bits
// - in-place shifts/rotates move bit through carry
// - sign mode one: arithmetic right shift
// - sign mode zero: logical right shift
// - left shift ignores sign mode, inserts zero
// - repeat iterates single-bit shifts
// - eight aux registers chosen by 3-bit pointer
// - aux and pointer loads; stores and alu use
// - autoindex by one or register zero
// - saturation mode clamps and sets overflow
`timescale 1ns/1ps
`default_nettype none
`include "cadp_cfg.svh"
module cadp_top (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire cadp_pkg::cadp_alu_req_s alu_req_in,
  input wire logic repeat_op_in,
  input wire logic [7:0] repeat_count_in,
  input wire logic sign_ext_mode_bit_in,
  input wire logic saturate_mode_bit_in,
  input wire logic overflow_clear_in,
  input wire cadp_pkg::cadp_cond_e cond_in,
  input wire logic [2:0] store_shift_in,
  input wire logic store_high_in,
  input wire cadp_pkg::cadp_aux_req_s aux_req_in,
  input wire logic [15:0] data_bus_in,
  input wire logic [31:0] product_reg_in,
  input wire logic [2:0] aux_rd_sel_in,
  output logic [31:0] accum_reg_out,
  output logic carry_out,
  output logic overflow_out,
  output logic cond_true_out,
  output logic busy_out,
  output logic [15:0] store_data_out,
  output logic [15:0] aux_rd_data_out,
  output logic [2:0] aux_pointer_out,
  output logic [15:0] aux_addr_out
);
  import cadp_pkg::*;
  typedef struct packed {
    cadp_core_state_s core;
    logic [7:0] rpt_left;
    cadp_op_e rpt_op;
  } cadp_top_s;
  cadp_top_s st_r, st_nxt;
  cadp_op_e op;
  logic op_valid;
  logic [32:0] sum;
  logic [31:0] acc;
  logic c;
  logic v;
  logic wrap_ov;

  // repeating shift/rotate re-applies the same single-bit op
  function automatic logic is_shift(input cadp_op_e o);
    is_shift = (o == CADP_OP_SHIFT_LEFT_INPLACE) || (o == CADP_OP_SHIFT_RIGHT_INPLACE) ||
               (o == CADP_OP_ROTATE_LEFT) || (o == CADP_OP_ROTATE_RIGHT);
  endfunction

  // select live op or a pending repeat step
  always_comb begin
    if (st_r.rpt_left != 8'h00) begin
      op = st_r.rpt_op;
      op_valid = 1'b1;
    end else begin
      op = alu_req_in.op;
      op_valid = alu_req_in.valid;
    end
  end

  // main datapath update; accum is the registered alu result
  always_comb begin
    st_nxt = st_r;
    acc = st_r.core.accum;
    c = st_r.core.carry;
    v = 1'b0;
    sum = 33'h000000000;
    wrap_ov = 1'b0;
    if (overflow_clear_in)
      st_nxt.core.overflow = 1'b0;
    if (op_valid) begin
      unique case (op)
        CADP_OP_NOP: acc = st_r.core.accum;
        CADP_OP_LOAD: acc = alu_req_in.operand; // loads leave carry
        CADP_OP_ADD, CADP_OP_ADD_WITH_CARRY: begin
          // previous carry feeds add-with-carry
          sum = {1'b0, acc} + {1'b0, alu_req_in.operand} +
                {32'h00000000, (op == CADP_OP_ADD_WITH_CARRY) ? st_r.core.carry : 1'b0};
          wrap_ov = (acc[31] == alu_req_in.operand[31]) && (sum[31] != acc[31]);
          acc = sum[31:0];
          c = sum[32];
        end
        CADP_OP_SUB, CADP_OP_SUB_WITH_BORROW: begin
          // borrow is inverted previous carry
          sum = {1'b0, acc} + {1'b0, ~alu_req_in.operand} +
                {32'h00000000, (op == CADP_OP_SUB_WITH_BORROW) ? st_r.core.carry : 1'b1};
          wrap_ov = (acc[31] != alu_req_in.operand[31]) && (sum[31] != acc[31]);
          acc = sum[31:0];
          c = sum[32];
        end
        CADP_OP_ADD_HIGH: begin
          sum = {1'b0, acc} + {1'b0, alu_req_in.operand[15:0], 16'h0000};
          wrap_ov = (acc[31] == alu_req_in.operand[15]) && (sum[31] != acc[31]);
          acc = sum[31:0];
          if (sum[32])
            c = 1'b1; // sets only, never clears
        end
        CADP_OP_SUB_HIGH: begin
          sum = {1'b0, acc} + {1'b0, ~alu_req_in.operand[15:0], 16'hffff} + 33'h000000001;
          wrap_ov = (acc[31] != alu_req_in.operand[15]) && (sum[31] != acc[31]);
          acc = sum[31:0];
          if (!sum[32])
            c = 1'b0; // clears only on borrow
        end
        // logical ops never touch carry or overflow
        CADP_OP_AND: acc = acc & alu_req_in.operand;
        CADP_OP_OR: acc = acc | alu_req_in.operand;
        CADP_OP_XOR: acc = acc ^ alu_req_in.operand;
        CADP_OP_SET_FLAG: c = 1'b1;
        CADP_OP_CLEAR_FLAG: c = 1'b0;
        CADP_OP_STATUS_LOAD: c = alu_req_in.status_carry;
        CADP_OP_SHIFT_LEFT_INPLACE: begin
          c = acc[31];
          acc = {acc[30:0], 1'b0}; // sign mode ignored
        end
        CADP_OP_SHIFT_RIGHT_INPLACE: begin
          c = acc[0];
          // arithmetic keeps sign logical inserts zero
          acc = {sign_ext_mode_bit_in ? acc[31] : 1'b0, acc[31:1]};
        end
        CADP_OP_ROTATE_LEFT: begin
          c = acc[31];
          acc = {acc[30:0], st_r.core.carry};
        end
        CADP_OP_ROTATE_RIGHT: begin
          c = acc[0];
          acc = {st_r.core.carry, acc[31:1]};
        end
        default: acc = st_r.core.accum;
      endcase
      // saturation clamps to extremes by overflow direction
      if (wrap_ov) begin
        v = 1'b1;
        if (saturate_mode_bit_in)
          acc = acc[31] ? `CADP_SAT_POS : `CADP_SAT_NEG;
      end
    end
    st_nxt.core.accum = acc;
    st_nxt.core.carry = c;
    if (v)
      st_nxt.core.overflow = 1'b1; // set wins over clear
    // repeat bookkeeping
    if (st_r.rpt_left != 8'h00) begin
      st_nxt.rpt_left = st_r.rpt_left - 8'h01;
    end else if (alu_req_in.valid && repeat_op_in && is_shift(alu_req_in.op)) begin
      st_nxt.rpt_left = repeat_count_in; // extra steps after this one
      st_nxt.rpt_op = alu_req_in.op;
    end
  end

  // synchronous reset; carry comes up set
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_r.core.accum <= 32'h00000000;
      st_r.core.carry <= `CADP_CARRY_RST;
      st_r.core.overflow <= 1'b0;
      st_r.rpt_left <= 8'h00;
      st_r.rpt_op <= CADP_OP_NOP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // carry tests for branch, call, return, conditional execute
  always_comb begin
    unique case (cond_in)
      CADP_COND_CARRY: cond_true_out = st_r.core.carry;
      CADP_COND_NO_CARRY: cond_true_out = !st_r.core.carry;
      default: cond_true_out = 1'b1;
    endcase
  end

  assign busy_out = (st_r.rpt_left != 8'h00);
  assign accum_reg_out = st_r.core.accum;
  assign carry_out = st_r.core.carry;
  assign overflow_out = st_r.core.overflow;

  // store path shifter, accumulator left intact
  cadp_post_shifter u_shift (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .accum_in(st_r.core.accum),
    .shift_in(store_shift_in),
    .high_sel_in(store_high_in),
    .store_data_out(store_data_out)
  );

  // aux register file and address unit
  cadp_aux_file u_aux (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .req_in(aux_req_in),
    .data_bus_in(data_bus_in),
    .accum_in(st_r.core.accum),
    .product_in(product_reg_in),
    .rd_sel_in(aux_rd_sel_in),
    .rd_data_out(aux_rd_data_out),
    .aux_state_out({aux_pointer_out, aux_addr_out})
  );
endmodule
`default_nettype wire

// *** cadp_top_props.sv ***
// checker on cadp_top ports: carry rules, in-place shifts, store path
// assumes one clock domain; bound below onto every cadp_top
`timescale 1ns/1ps
`default_nettype none
module cadp_top_props (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire cadp_pkg::cadp_alu_req_s alu_req_in,
  input wire logic repeat_op_in,
  input wire logic sign_ext_mode_bit_in,
  input wire logic saturate_mode_bit_in,
  input wire cadp_pkg::cadp_cond_e cond_in,
  input wire logic [2:0] store_shift_in,
  input wire logic store_high_in,
  input wire logic [31:0] accum_reg_out,
  input wire logic carry_out,
  input wire logic cond_true_out,
  input wire logic busy_out,
  input wire logic [15:0] store_data_out
);
  import cadp_pkg::*;
  logic [31:0] sh_w;
  logic [15:0] st_exp;
  // expected store word; high half pulls bits up from the low half
  always_comb begin
    sh_w = accum_reg_out << store_shift_in;
    st_exp = store_high_in ? sh_w[31:16] : sh_w[15:0];
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // op taken at this edge; busy refuses new ops
  sequence s_take(cadp_op_e o);
    alu_req_in.valid && !busy_out && alu_req_in.op == o;
  endsequence
  // single step, no clamp in the way
  sequence s_one(cadp_op_e o);
    s_take(o) ##0 !repeat_op_in && !saturate_mode_bit_in;
  endsequence
  chk_reset_carry: assert property (disable iff (1'b0) !rst_n_in |=> carry_out)
    else $error("carry not one after reset");
  chk_load_keeps: assert property (s_take(CADP_OP_LOAD) |=> $stable(carry_out))
    else $error("load changed carry");
  chk_addh_noclr: assert property (s_take(CADP_OP_ADD_HIGH) ##0 carry_out |=> carry_out)
    else $error("add high cleared carry");
  chk_subh_noset: assert property (s_take(CADP_OP_SUB_HIGH) ##0 !carry_out |=> !carry_out)
    else $error("sub high set carry");
  chk_set_flag: assert property (s_take(CADP_OP_SET_FLAG) |=> carry_out)
    else $error("set flag failed");
  chk_cond_carry: assert property (cond_in != CADP_COND_ALWAYS |->
    cond_true_out == (carry_out ^ (cond_in == CADP_COND_NO_CARRY)))
    else $error("carry condition wrong");
  chk_shl_zero: assert property (s_one(CADP_OP_SHIFT_LEFT_INPLACE) |=>
    {carry_out, accum_reg_out} == {$past(accum_reg_out), 1'b0})
    else $error("left shift wrong");
  chk_shr_mode: assert property (s_one(CADP_OP_SHIFT_RIGHT_INPLACE) |=>
    {accum_reg_out, carry_out} == {$past(sign_ext_mode_bit_in) & $past(accum_reg_out[31]), $past(accum_reg_out)})
    else $error("right shift wrong");
  chk_rol_carry: assert property (s_one(CADP_OP_ROTATE_LEFT) |=>
    {carry_out, accum_reg_out} == {$past(accum_reg_out), $past(carry_out)})
    else $error("rotate left wrong");
  chk_store_path: assert property (1'b1 |=> store_data_out == $past(st_exp))
    else $error("store word wrong");
endmodule
bind cadp_top cadp_top_props u_props (
  .core_clk_in, .rst_n_in, .alu_req_in, .repeat_op_in, .sign_ext_mode_bit_in, .saturate_mode_bit_in,
  .cond_in, .store_shift_in, .store_high_in, .accum_reg_out, .carry_out, .cond_true_out, .busy_out,
  .store_data_out
);
`default_nettype wire

// *** cadp_top_test.sv ***
// self-checking bench for cadp_top: alu ops, store path, aux file
// assumes cadp_top_props is bound; one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module cadp_top_test;
  import cadp_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  cadp_alu_req_s alu_req_in = '0;
  cadp_aux_req_s aux_req_in = '0;
  logic rep = 1'b0, sign_ext_mode_bit = 1'b0, sat = 1'b0, ovc = 1'b0, hi = 1'b0;
  logic [7:0] rcnt = 8'h00;
  cadp_cond_e cond = CADP_COND_ALWAYS;
  logic [2:0] sh = 3'h0, sel = 3'h3, ptr;
  logic [15:0] dbus = 16'h0a0a, sd, ard, aadr;
  logic [31:0] prod = 32'h0000_0b0b, acc, e;
  logic cy, ov, ct, busy;
  int err_total = 0, check_count = 0;
  always #5 core_clk_in = ~core_clk_in;
  cadp_top dut (.core_clk_in, .rst_n_in, .alu_req_in, .repeat_op_in(rep), .repeat_count_in(rcnt),
    .sign_ext_mode_bit_in(sign_ext_mode_bit), .saturate_mode_bit_in(sat), .overflow_clear_in(ovc), .cond_in(cond),
    .store_shift_in(sh), .store_high_in(hi), .aux_req_in, .data_bus_in(dbus), .product_reg_in(prod),
    .aux_rd_sel_in(sel), .accum_reg_out(acc), .carry_out(cy), .overflow_out(ov), .cond_true_out(ct),
    .busy_out(busy), .store_data_out(sd), .aux_rd_data_out(ard), .aux_pointer_out(ptr), .aux_addr_out(aadr));
  // counted compare, mismatch reported at once
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one op for one cycle, then wait out repeat steps (bounded)
  task automatic op(input cadp_op_e o, input logic [31:0] v, input logic [7:0] n = 8'h00);
    int k;
    @(posedge core_clk_in);
    alu_req_in <= '{1'b1, o, v, v[0]};
    rep <= (n != 8'h00);
    rcnt <= n;
    @(posedge core_clk_in);
    alu_req_in.valid <= 1'b0;
    rep <= 1'b0;
    k = 0;
    @(negedge core_clk_in);
    while (busy === 1'b1 && k < 300) begin
      @(negedge core_clk_in);
      k++;
    end
  endtask
  // one aux request; extra edge lets the registered read port catch up
  task automatic ax(input logic [1:0] lp, input cadp_src_e s, input logic [15:0] im, input cadp_aau_e a);
    @(posedge core_clk_in);
    aux_req_in <= '{lp[1], lp[0], s, im, im[2:0], a, a != CADP_AAU_NONE};
    @(posedge core_clk_in);
    aux_req_in <= '0;
    @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  initial begin
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(negedge core_clk_in);
    cmp(cy, 32'h1);
    op(CADP_OP_CLEAR_FLAG, 0);
    cmp(cy, 32'h0);
    op(CADP_OP_LOAD, 32'h8000_0001);
    op(CADP_OP_XOR, 32'h0000_ffff);
    cmp(acc, 32'h8000_fffe);
    cmp(cy, 32'h0);
    op(CADP_OP_STATUS_LOAD, 1);
    cmp(cy, 32'h1);
    op(CADP_OP_LOAD, 5);
    op(CADP_OP_ADD_WITH_CARRY, 3);
    cmp(acc, 32'h9);
    op(CADP_OP_CLEAR_FLAG, 0);
    op(CADP_OP_SUB_WITH_BORROW, 2);
    cmp(acc, 32'h6);
    op(CADP_OP_LOAD, 32'hffff_ffff);
    op(CADP_OP_CLEAR_FLAG, 0);
    op(CADP_OP_ADD, 1);
    cmp({acc[30:0], cy}, 32'h1);
    op(CADP_OP_CLEAR_FLAG, 0);
    op(CADP_OP_ADD_HIGH, 1);
    cmp({acc[30:0], cy}, 32'h0002_0000);
    op(CADP_OP_LOAD, 32'hffff_0000);
    op(CADP_OP_ADD_HIGH, 1);
    cmp({acc[30:0], cy}, 32'h1);
    op(CADP_OP_SUB_HIGH, 0);
    cmp(cy, 32'h1);
    op(CADP_OP_SUB_HIGH, 1);
    cmp({acc[30:0], cy}, 32'hfffe_0000);
    $display("carry tests done");
    // both sign modes; left shift must not care
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk_in);
      sign_ext_mode_bit <= m[0];
      op(CADP_OP_LOAD, 32'h8000_0003);
      op(CADP_OP_SHIFT_RIGHT_INPLACE, 0);
      cmp(acc, {m[0], 31'h4000_0001});
      cmp(cy, 32'h1);
      op(CADP_OP_SHIFT_LEFT_INPLACE, 0);
      cmp({acc[30:0], cy}, {31'h0000_0002, m[0]});
    end
    op(CADP_OP_LOAD, 32'h8000_0001);
    op(CADP_OP_ROTATE_LEFT, 0);
    cmp({acc[30:0], cy}, 32'h0000_0007);
    op(CADP_OP_ROTATE_RIGHT, 0);
    cmp(acc, 32'h8000_0001);
    cmp(cy, 32'h1);
    op(CADP_OP_LOAD, 1);
    op(CADP_OP_ROTATE_LEFT, 0, 8'h02);
    cmp(acc, 32'h0000_000c);
    @(posedge core_clk_in);
    sat <= 1'b1;
    op(CADP_OP_LOAD, 32'h7fff_ffff);
    op(CADP_OP_ADD, 1);
    cmp({acc[30:0], ov}, 32'hffff_ffff);
    op(CADP_OP_LOAD, 32'h8000_0000);
    op(CADP_OP_SUB, 1);
    cmp(acc, 32'h8000_0000);
    @(posedge core_clk_in);
    ovc <= 1'b1;
    sat <= 1'b0;
    op(CADP_OP_LOAD, 32'h1234_5678);
    ovc <= 1'b0;
    cmp(ov, 32'h0);
    $display("shift tests done");
    // every store shift on both halves
    for (int s = 0; s < 16; s++) begin
      @(posedge core_clk_in);
      sh <= s[2:0];
      hi <= s[3];
      @(posedge core_clk_in);
      @(negedge core_clk_in);
      e = 32'h1234_5678 << s[2:0];
      cmp(sd, s[3] ? e[31:16] : e[15:0]);
    end
    cmp(acc, 32'h1234_5678);
    for (int k = 0; k < 6; k++) begin
      if (k % 3 == 0) op(k ? CADP_OP_CLEAR_FLAG : CADP_OP_SET_FLAG, 0);
      @(posedge core_clk_in);
      cond <= cadp_cond_e'(k % 3);
      @(negedge core_clk_in);
      cmp(ct, (k % 3 == 0) || ((k % 3 == 1) == (k < 3)));
    end
    $display("store tests done");
    ax(2'b01, CADP_SRC_IMM, 16'h0000, CADP_AAU_NONE);
    ax(2'b10, CADP_SRC_IMM, 16'h0010, CADP_AAU_NONE);
    ax(2'b01, CADP_SRC_IMM, 16'h0003, CADP_AAU_NONE);
    ax(2'b10, CADP_SRC_IMM, 16'h0100, CADP_AAU_NONE);
    cmp({ptr, ard}, 32'h0003_0100);
    e = 32'h0000_0100;
    // inc, dec, plus and minus register zero in turn
    for (int a = 1; a < 5; a++) begin
      ax(2'b00, CADP_SRC_IMM, 16'h0000, cadp_aau_e'(a));
      cmp(aadr, e);
      e = (a == 1) ? e + 1 : (a == 2) ? e - 1 : (a == 3) ? e + 16 : e - 16;
      cmp(ard, e);
    end
    for (int q = 0; q < 4; q++) begin
      ax(2'b10, cadp_src_e'(q), 16'h0c0c, CADP_AAU_NONE);
      cmp(ard, q == 0 ? 32'h0a0a : q == 1 ? 32'h5678 : q == 2 ? 32'h0b0b : 32'h0c0c);
    end
    $display("aux tests done");
    end_sim;
  end
  // hang guard: the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge core_clk_in);
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire
